// file: hdl/pems_regs.vh
// Purpose: constants for the pattern-check and eye-monitor status block
// Assumes: 8-bit register index, 16-bit register data
// Notes:   offsets are register indices on the serial control port
`ifndef PEMS_REGS_VH
`define PEMS_REGS_VH
`define PEMS_IDX_ERR_CNT     8'h89
`define PEMS_IDX_CHK_STATUS  8'h8A
`define PEMS_IDX_SEG_SIZE    8'h8B
`define PEMS_IDX_SHAPE_LEFT  8'h8C
`define PEMS_IDX_SHAPE_TOP   8'h8D
`define PEMS_IDX_SHAPE_RIGHT 8'h8E
`define PEMS_IDX_SHAPE_BOT   8'h8F
`define PEMS_IDX_EYE_STATUS  8'h90
`define PEMS_ST_IDLE         2'h0
`define PEMS_ST_BUSY         2'h1
`define PEMS_ST_DONE         2'h2
`define PEMS_ST_ABORT        2'h3
`define PEMS_PHASE_MAX       8'h7F
`define PEMS_ZERO16          16'h0000
`endif

// file: hdl/pems_status.v
// Purpose: status registers of the pattern checker and eye monitor
// Assumes: engine done pulses come from logic on mclk; lock/sleep are pins
// Notes:   register reads are combinational over rd_index; no writes exist
`timescale 1ns/1ns
`include "pems_regs.vh"
module pems_status (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        lock_pin,
   input  wire        sleep_pin,
   input  wire        check_start_control,
   input  wire        chk_done,
   input  wire        chk_timed,
   input  wire        chk_all_zero,
   input  wire [15:0] chk_errors,
   input  wire        eye_start_control,
   input  wire        eye_power_bit,
   input  wire        eye_shape_select,
   input  wire        eye_done,
   input  wire        eye_partial,
   input  wire [15:0] eye_seg_size,
   input  wire [63:0] eye_edges,
   input  wire [7:0]  rd_index,
   output reg  [15:0] rd_data,
   output wire        chk_run,
   output wire        eye_run
);
   // Synchronised pin levels and the fault made from them
   wire        lock_ok;
   wire        asleep;
   wire        fault;

   // Pattern checker state and its next values
   reg  [1:0]  check_op_state;
   reg  [1:0]  next_check_op_state;
   reg         check_abort_flag;
   reg         next_check_abort_flag;
   reg         check_no_transition_flag;
   reg         next_check_no_transition_flag;
   reg  [15:0] check_error_count;
   reg  [15:0] next_check_error_count;
   reg         chk_start_d;
   wire        chk_req;

   // Eye monitor state and its next values
   reg  [1:0]  eye_op_state;
   reg  [1:0]  next_eye_op_state;
   reg         scan_extent;
   reg         next_scan_extent;
   reg  [15:0] segment_byte_size;
   reg  [15:0] next_segment_byte_size;
   reg         eye_start_d;
   wire        eye_req;
   wire        shape_capture;
   reg  [15:0] shape_edge [0:3];
   integer     i;

   // Read-back words
   wire [15:0] check_status_word;
   wire [15:0] eye_status_word;

   // Lock and sleep arrive from outside the clock domain
   pems_pin_sync lock_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   (lock_pin),
      .level (lock_ok)
   );

   pems_pin_sync sleep_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .pin   (sleep_pin),
      .level (asleep)
   );

   // Lock reads low out of reset, so a fault stands until lock settles
   assign fault   = !lock_ok || asleep;
   assign chk_req = check_start_control && !chk_start_d;
   assign eye_req = eye_start_control && !eye_start_d;
   assign chk_run = (check_op_state == `PEMS_ST_BUSY);
   assign eye_run = (eye_op_state == `PEMS_ST_BUSY);

   // Shape results are taken only on a clean shape completion
   assign shape_capture = eye_run && !fault && eye_done && eye_shape_select;

   // Pattern checker next state; flags move only at request or end
   always @* begin
      next_check_op_state           = check_op_state;
      next_check_abort_flag         = check_abort_flag;
      next_check_no_transition_flag = check_no_transition_flag;
      next_check_error_count        = check_error_count;
      case (check_op_state)
         `PEMS_ST_IDLE: begin
            if (chk_req) begin
               next_check_abort_flag         = fault;
               next_check_no_transition_flag = 1'b0;
               next_check_error_count        = `PEMS_ZERO16;
               if (fault) begin
                  next_check_op_state = `PEMS_ST_ABORT;
               end else begin
                  next_check_op_state = `PEMS_ST_BUSY;
               end
            end
         end
         `PEMS_ST_BUSY: begin
            if (fault) begin
               // No-transition flag and error count left as is: content undefined after abort
               next_check_abort_flag = 1'b1;
               next_check_op_state   = `PEMS_ST_ABORT;
            end else if (chk_done) begin
               next_check_no_transition_flag = chk_all_zero;
               next_check_error_count        = chk_errors;
               if (chk_timed) begin
                  next_check_op_state = `PEMS_ST_DONE;
               end else begin
                  next_check_op_state = `PEMS_ST_IDLE;
               end
            end else if (!check_start_control && !chk_timed) begin
               // Continuous run ends when host drops start
               next_check_no_transition_flag = chk_all_zero;
               next_check_error_count        = chk_errors;
               next_check_op_state           = `PEMS_ST_IDLE;
            end
         end
         `PEMS_ST_DONE, `PEMS_ST_ABORT: begin
            if (!check_start_control) begin
               next_check_op_state = `PEMS_ST_IDLE;
            end
         end
         default: begin
            next_check_op_state = `PEMS_ST_IDLE;
         end
      endcase
   end

   // Pattern checker registers
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         chk_start_d              <= 1'b0;
         check_op_state           <= `PEMS_ST_IDLE;
         check_abort_flag         <= 1'b0;
         check_no_transition_flag <= 1'b0;
         check_error_count        <= `PEMS_ZERO16;
      end else begin
         chk_start_d              <= check_start_control;
         check_op_state           <= next_check_op_state;
         check_abort_flag         <= next_check_abort_flag;
         check_no_transition_flag <= next_check_no_transition_flag;
         check_error_count        <= next_check_error_count;
      end
   end

   // Eye monitor next state; power and select are host duties
   always @* begin
      next_eye_op_state      = eye_op_state;
      next_scan_extent       = scan_extent;
      next_segment_byte_size = segment_byte_size;
      case (eye_op_state)
         `PEMS_ST_IDLE: begin
            // Start without power is ignored, not aborted
            if (eye_req && eye_power_bit) begin
               if (fault) begin
                  next_eye_op_state = `PEMS_ST_ABORT;
               end else begin
                  next_eye_op_state = `PEMS_ST_BUSY;
               end
            end
         end
         `PEMS_ST_BUSY: begin
            if (fault) begin
               next_eye_op_state = `PEMS_ST_ABORT;
            end else if (eye_done) begin
               next_eye_op_state = `PEMS_ST_DONE;
               if (!eye_shape_select) begin
                  next_scan_extent = eye_partial;
                  if (eye_partial) begin
                     next_segment_byte_size = eye_seg_size;
                  end
               end
            end
         end
         `PEMS_ST_DONE, `PEMS_ST_ABORT: begin
            if (!eye_start_control) begin
               next_eye_op_state = `PEMS_ST_IDLE;
            end
         end
         default: begin
            next_eye_op_state = `PEMS_ST_IDLE;
         end
      endcase
   end

   // Eye monitor registers
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         eye_start_d       <= 1'b0;
         eye_op_state      <= `PEMS_ST_IDLE;
         scan_extent       <= 1'b0;
         segment_byte_size <= `PEMS_ZERO16;
      end else begin
         eye_start_d       <= eye_start_control;
         eye_op_state      <= next_eye_op_state;
         scan_extent       <= next_scan_extent;
         segment_byte_size <= next_segment_byte_size;
      end
   end

   // Shape edges: left, top, right, bottom in slice order
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 4; i = i + 1) begin
            shape_edge[i] <= `PEMS_ZERO16;
         end
      end else if (shape_capture) begin
         for (i = 0; i < 4; i = i + 1) begin
            shape_edge[i][15:8] <= eye_edges[i*16+8 +: 8];
            // Out-of-range phase clamps rather than wraps
            if (eye_edges[i*16 +: 8] > `PEMS_PHASE_MAX) begin
               shape_edge[i][7:0] <= `PEMS_PHASE_MAX;
            end else begin
               shape_edge[i][7:0] <= eye_edges[i*16 +: 8];
            end
         end
      end
   end

   // Status words; reserved bits read as zero
   assign check_status_word = {6'h00, check_no_transition_flag,
                               check_abort_flag, 6'h00, check_op_state};
   assign eye_status_word   = {7'h00, scan_extent, 6'h00, eye_op_state};

   // Read-only map; no write path exists
   always @* begin
      case (rd_index)
         `PEMS_IDX_ERR_CNT:     rd_data = check_error_count;
         `PEMS_IDX_CHK_STATUS:  rd_data = check_status_word;
         `PEMS_IDX_SEG_SIZE:    rd_data = segment_byte_size;
         `PEMS_IDX_SHAPE_LEFT:  rd_data = shape_edge[0];
         `PEMS_IDX_SHAPE_TOP:   rd_data = shape_edge[1];
         `PEMS_IDX_SHAPE_RIGHT: rd_data = shape_edge[2];
         `PEMS_IDX_SHAPE_BOT:   rd_data = shape_edge[3];
         `PEMS_IDX_EYE_STATUS:  rd_data = eye_status_word;
         default:               rd_data = `PEMS_ZERO16;
      endcase
   end

endmodule // pems_status

// Three flops; the level moves once the last two agree
// Costs four cycles from pin to level but filters single-cycle glitches
module pems_pin_sync (
   input  wire mclk,
   input  wire rst_n,
   input  wire pin,
   output reg  level
);
   reg [2:0] stage;

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage <= 3'h0;
         level <= 1'b0;
      end else begin
         stage <= {stage[1:0], pin};
         if (stage[2] == stage[1]) begin
            level <= stage[2];
         end
      end
   end

endmodule // pems_pin_sync

// file: tb/pems_assertions.sv
// Purpose: port assertions for the status block
// Assumes: lock and sleep pass a three-flop synchroniser
// Notes:   bound to every pems_status instance
`timescale 1ns/1ns
module pems_assertions (
   input wire        mclk,
   input wire        rst_n,
   input wire        sleep_pin,
   input wire        check_start_control,
   input wire        chk_done,
   input wire        eye_start_control,
   input wire        eye_power_bit,
   input wire        eye_done,
   input wire [7:0]  rd_index,
   input wire [15:0] rd_data,
   input wire        chk_run,
   input wire        eye_run
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_CHK_GO: assert property ($rose(chk_run) |-> $past(check_start_control))
      else $error("check busy without start");
   AST_CHK_END: assert property (chk_run && chk_done |=> !chk_run)
      else $error("check still busy after done");
   AST_EYE_GO: assert property ($rose(eye_run) |->
      $past(eye_power_bit && eye_start_control))
      else $error("eye busy without power and start");
   AST_EYE_END: assert property (eye_run && eye_done |=> !eye_run)
      else $error("eye still busy after done");
   AST_SLEEP: assert property (sleep_pin [*6] |-> !chk_run && !eye_run)
      else $error("operation survives sleep");
   AST_CHK_FMT: assert property (rd_index == 8'h8A |-> (rd_data & 16'hFCFC)
      == 16'h0000 && chk_run == (rd_data[1:0] == 2'h1))
      else $error("check status layout wrong");
   AST_EYE_FMT: assert property (rd_index == 8'h90 |-> (rd_data & 16'hFEFC)
      == 16'h0000 && eye_run == (rd_data[1:0] == 2'h1))
      else $error("eye status layout wrong");
   AST_PHASE: assert property (rd_index[7:2] == 6'h23 |-> rd_data[7:0] <= 8'h7F)
      else $error("edge phase out of range");
   AST_UNMAPPED: assert property (rd_index == 8'h91 |-> rd_data == 16'h0000)
      else $error("reserved index not zero");
endmodule // pems_assertions
bind pems_status pems_assertions chk (.mclk, .rst_n, .sleep_pin,
   .check_start_control, .chk_done, .eye_start_control, .eye_power_bit,
   .eye_done, .rd_index, .rd_data, .chk_run, .eye_run);

// file: tb/pems_host.sv
// Purpose: host side of the start/clear handshakes
// Assumes: caller waits for done or abort before clearing, except to end a continuous check
// Notes:   power is raised a cycle ahead of start
`timescale 1ns/1ns
module pems_host (
   input  wire  mclk,
   output logic check_start_control = 1'b0,
   output logic eye_start_control = 1'b0,
   output logic eye_power_bit = 1'b0,
   output logic eye_shape_select = 1'b0
);
   task automatic chk(input logic on);
      @(posedge mclk) check_start_control <= on;
   endtask
   task automatic eye(input logic on, input logic shape);
      @(posedge mclk) begin
         eye_power_bit    <= 1'b1;
         eye_shape_select <= shape;
      end
      @(posedge mclk) eye_start_control <= on;
   endtask
endmodule // pems_host

// file: tb/prbs_and_eye_monitor_status_test.sv
// Purpose: directed test of the status block
// Assumes: lock high except in the lock-loss test
// Notes:   result data inputs fixed; control levels driven
`timescale 1ns/1ns
module prbs_and_eye_monitor_status_test;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sleep_pin = 1'b0;
   logic        lock_pin = 1'b1;
   logic        chk_timed = 1'b1;
   logic        chk_all_zero = 1'b1;
   logic        chk_done = 1'b0;
   logic        eye_done = 1'b0;
   logic        eye_partial = 1'b0;
   logic [7:0]  rd_index = 8'h00;
   logic [15:0] rd_data;
   logic        chk_run, eye_run, cs, es, ep, ss;
   int          n_fail = 0;
   int          comparisons = 0;
   pems_host h (.mclk, .check_start_control(cs), .eye_start_control(es),
      .eye_power_bit(ep), .eye_shape_select(ss));
   pems_status dut (.mclk, .rst_n, .lock_pin, .sleep_pin,
      .check_start_control(cs), .chk_done, .chk_timed,
      .chk_all_zero, .chk_errors(16'h0005), .eye_start_control(es),
      .eye_power_bit(ep), .eye_shape_select(ss), .eye_done, .eye_partial,
      .eye_seg_size(16'h1234), .eye_edges(64'h807F7F80FF400010),
      .rd_index, .rd_data, .chk_run, .eye_run);
   initial forever #10 mclk = ~mclk;
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic see(input logic [7:0] i, input logic [15:0] m, e);
      @(posedge mclk) rd_index <= i;
      @(posedge mclk) #1;
      comparisons++;
      if ((rd_data & m) !== e) begin
         n_fail++;
         $display("BAD reg %h expected %h seen %h", i, e, rd_data & m);
      end
   endtask
   task automatic wait_run(input logic eye);
      int k;
      for (k = 0; k < 10 && (eye ? eye_run : chk_run) !== 1'b1; k++)
         @(posedge mclk) #1;
      if (k == 10) begin
         n_fail++;
         $display("BAD busy flag expected 1 seen 0");
         report_and_stop();
      end
   endtask
   task automatic done(input logic eye);
      @(posedge mclk) {chk_done, eye_done} <= {!eye, eye};
      @(posedge mclk) {chk_done, eye_done} <= 2'h0;
   endtask
   task automatic test_timed_check;
      see(8'h8A, 16'hFFFF, 16'h0000);
      see(8'h91, 16'hFFFF, 16'h0000);
      h.chk(1'b1);
      wait_run(1'b0);
      see(8'h89, 16'hFFFF, 16'h0000);
      done(1'b0);
      see(8'h8A, 16'hFFFF, 16'h0202);
      see(8'h89, 16'hFFFF, 16'h0005);
      h.chk(1'b0);
      see(8'h8A, 16'hFFFF, 16'h0200);
      $display("timed check test ended");
   endtask
   task automatic test_sleep_abort;
      h.chk(1'b1);
      wait_run(1'b0);
      @(posedge mclk) sleep_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      see(8'h8A, 16'h01FF, 16'h0103);
      h.chk(1'b0);
      @(posedge mclk) sleep_pin <= 1'b0;
      see(8'h8A, 16'h01FF, 16'h0100);
      repeat (6) @(posedge mclk);
      $display("abort test ended");
   endtask
   task automatic test_lock_request;
      @(posedge mclk) lock_pin <= 1'b0;
      repeat (6) @(posedge mclk);
      h.chk(1'b1);
      see(8'h8A, 16'h01FF, 16'h0103);
      h.chk(1'b0);
      see(8'h8A, 16'h01FF, 16'h0100);
      @(posedge mclk) lock_pin <= 1'b1;
      repeat (6) @(posedge mclk);
      $display("lock loss test ended");
   endtask
   task automatic test_continuous;
      @(posedge mclk) begin
         chk_timed    <= 1'b0;
         chk_all_zero <= 1'b0;
      end
      h.chk(1'b1);
      wait_run(1'b0);
      see(8'h8A, 16'hFFFF, 16'h0001);
      h.chk(1'b0);
      see(8'h8A, 16'hFFFF, 16'h0000);
      see(8'h89, 16'hFFFF, 16'h0005);
      @(posedge mclk) begin
         chk_timed    <= 1'b1;
         chk_all_zero <= 1'b1;
      end
      $display("continuous check test ended");
   endtask
   task automatic test_shape;
      h.eye(1'b1, 1'b1);
      wait_run(1'b1);
      done(1'b1);
      see(8'h90, 16'hFEFF, 16'h0002);
      for (int i = 0; i < 4; i++)
         see(8'(8'h8C + i), 16'hFFFF,
            16'(64'h807F7F7FFF400010 >> (16 * i)));
      h.eye(1'b0, 1'b1);
      see(8'h90, 16'h0003, 16'h0000);
      $display("shape capture test ended");
   endtask
   task automatic test_partial;
      @(posedge mclk) eye_partial <= 1'b1;
      h.eye(1'b1, 1'b0);
      wait_run(1'b1);
      done(1'b1);
      see(8'h90, 16'hFFFF, 16'h0102);
      see(8'h8B, 16'hFFFF, 16'h1234);
      h.eye(1'b0, 1'b0);
      $display("partial scan test ended");
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
      test_timed_check();
      test_sleep_abort();
      test_lock_request();
      test_continuous();
      test_shape();
      test_partial();
      report_and_stop();
   end
endmodule // prbs_and_eye_monitor_status_test
